// ### include/ppp_defs.svh
// Constant definitions for the parallel programming port
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH
`define PPP_XA_ADDR 2'b00
`define PPP_XA_DATA 2'b01
`define PPP_XA_CMD 2'b10
`define PPP_BS_LOW 2'b00
`define PPP_BS_HIGH 2'b01
`define PPP_BS_EXT 2'b10
`define PPP_BS_RSV 2'b11
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EE 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EE 8'h03
`define PPP_WORD_BITS 6
`define PPP_PAGE_WORDS 64
`define PPP_BYTE_FF 8'hFF
`define PPP_T_CLK_NS 20
`define PPP_T_ENTRY_NS 100
`define PPP_T_ERASE_NS 40000
`define PPP_T_PROG_NS 20000
`define PPP_T_FUSE_NS 5000
`define PPP_ENTRY_CYC ((`PPP_T_ENTRY_NS + `PPP_T_CLK_NS - 1) / `PPP_T_CLK_NS)
`define PPP_ERASE_CYC ((`PPP_T_ERASE_NS + `PPP_T_CLK_NS - 1) / `PPP_T_CLK_NS)
`define PPP_PROG_CYC ((`PPP_T_PROG_NS + `PPP_T_CLK_NS - 1) / `PPP_T_CLK_NS)
`define PPP_FUSE_CYC ((`PPP_T_FUSE_NS + `PPP_T_CLK_NS - 1) / `PPP_T_CLK_NS)
`define PPP_SIG_IDX_CAL 8'h00
`endif

// ### include/ppp_pkg.sv
// Types shared by the parallel programming port
package ppp_pkg;
   typedef struct packed {
      logic hv;
      logic page_latch_strobe;
      logic action_sel_hi;
      logic action_sel_lo;
      logic byte_sel_hi;
      logic byte_sel_lo;
      logic action_strobe;
      logic wr_n;
      logic oe_n;
      logic [7:0] data;
   } ppp_pins_t;
   typedef enum logic [1:0] {
      PPP_IDLE = 2'b00,
      PPP_ERASE = 2'b01,
      PPP_LOCK_REL = 2'b10,
      PPP_PROG = 2'b11
   } ppp_state_t;
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic [7:0] ext;
      logic [7:0] lock;
   } ppp_fuses_t;
endpackage

// ### rtl/ppp_top.sv
// Parallel programming port decoder and page buffer
`timescale 1ns/1ps
`include "ppp_defs.svh"

// Functional notes
// RULE1: Action select picks address, data, command, idle
// RULE2: Byte select routes address to low/high/extended
// RULE3: Address bytes form bits 7-0, 15-8, 23-16
// RULE4: First byte select picks data low/high
// RULE5: Erase and write command bytes decoded
// RULE6: Read command bytes decoded
// RULE7: Programmer toggles strobe six times under reset
// RULE8: Programmer sets entry pins zero, waits 100 ns
// RULE9: Entry pin change within 100 ns blocks entry
// RULE10: Programmer waits 50 us before first command
// RULE11: Command and address persist across operations
// RULE12: Programmer reloads high byte per window
// RULE13: Programmer may skip 0xFF after erase
// RULE14: Erase clears memories, locks released after, fuses kept
// RULE15: Preserve fuse keeps EEPROM through erase
// RULE16: Programmer erases before reprogramming
// RULE17: Write strobe starts erase, busy low
// RULE18: Page latch stores data word at address
// RULE19: Low address bits pick word, upper pick page
// RULE20: Write strobe programs page buffer, busy low
// RULE21: Busy low during operation, high when ready
// RULE22: Data bus driven only while output enable low
// RULE23: Fuse read selects low, lock, ext, high
// RULE24: Fuse write selects low, high, ext byte
// RULE25: High voltage is one qualifying input
// RULE26: Busy ignores strobes, entry clears registers
module ppp_top
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire ppp_pkg::ppp_pins_t pins_i,
   input wire logic eeprom_preserve_fuse_i,
   input wire logic [15:0] flash_rd_data_i,
   input wire logic [7:0] ee_rd_data_i,
   input wire logic [`PPP_WORD_BITS-1:0] pbuf_rd_idx_i,
   output logic [15:0] pbuf_rd_data_o,
   output logic [23:0] mem_addr_o,
   output logic [7:0] data_o,
   output logic data_oe_o,
   output logic ready_not_busy_o,
   output logic prog_mode_o,
   output logic flash_page_wr_o,
   output logic ee_page_wr_o,
   output logic chip_erase_o,
   output logic ee_erase_o,
   output logic lock_release_o,
   output ppp_pkg::ppp_fuses_t fuses_o
);
   import ppp_pkg::*;

   // Arbitrary identification values, not tied to any part
   localparam logic [7:0] SIG_BYTE0 = 8'h5A;
   localparam logic [7:0] SIG_BYTE1 = 8'hA5;
   localparam logic [7:0] SIG_BYTE2 = 8'h3C;
   localparam logic [7:0] CAL_BYTE = 8'h80;

   logic rst_s1_q;
   logic rst_q;
   ppp_pins_t sync1_q;
   ppp_pins_t pin_q;
   ppp_pins_t prev_q;
   logic [7:0] cmd_q;
   logic [23:0] addr_q;
   logic [7:0] dlo_q;
   logic [7:0] dhi_q;
   logic [15:0] pbuf_q [0:`PPP_PAGE_WORDS-1];
   ppp_state_t state_q;
   logic [11:0] cnt_q;
   logic [2:0] ent_cnt_q;
   logic ent_fail_q;
   logic ent_run_q;
   logic prog_q;
   ppp_fuses_t fuse_q;
   logic [7:0] rd_d;
   logic strobe_rise;
   logic latch_rise;
   logic wr_fall;
   logic hv_rise;
   logic entry_pins;
   logic idle;
   logic [1:0] xa;
   logic [1:0] bs;

   // Release of the asynchronous reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_q <= rst_s1_q;
      end
   end

   // Pins are asynchronous to the clock; prev_q feeds edge detection
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         sync1_q <= '0;
         pin_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         sync1_q <= pins_i;
         pin_q <= sync1_q;
         prev_q <= pin_q;
      end
   end

   assign xa = {pin_q.action_sel_hi, pin_q.action_sel_lo};
   assign bs = {pin_q.byte_sel_hi, pin_q.byte_sel_lo};
   assign idle = (state_q == PPP_IDLE);
   // Strobes count only in programming mode and when not busy
   assign strobe_rise = prog_q & idle & pin_q.action_strobe & ~prev_q.action_strobe; // see RULE26
   assign latch_rise = prog_q & idle & pin_q.page_latch_strobe & ~prev_q.page_latch_strobe;
   assign wr_fall = prog_q & idle & ~pin_q.wr_n & prev_q.wr_n; // see RULE26
   assign hv_rise = pin_q.hv & ~prev_q.hv; // see RULE25
   assign entry_pins = pin_q.page_latch_strobe | pin_q.action_sel_hi
                       | pin_q.action_sel_lo | pin_q.byte_sel_lo;

   // Entry qualification window after high voltage appears
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         ent_cnt_q <= 3'h0;
         ent_run_q <= 1'b0;
         ent_fail_q <= 1'b0;
         prog_q <= 1'b0;
      end
      else if (!pin_q.hv)
      begin
         ent_run_q <= 1'b0;
         ent_fail_q <= 1'b0;
         prog_q <= 1'b0; // see RULE25
      end
      else if (hv_rise)
      begin
         ent_run_q <= 1'b1;
         ent_cnt_q <= 3'h0;
         ent_fail_q <= entry_pins;
      end
      else if (ent_run_q)
      begin
         if (entry_pins)
            ent_fail_q <= 1'b1; // see RULE9
         if (ent_cnt_q == 3'(`PPP_ENTRY_CYC - 1))
         begin
            ent_run_q <= 1'b0;
            prog_q <= ~(ent_fail_q | entry_pins); // see RULE9
         end
         else
            ent_cnt_q <= ent_cnt_q + 3'h1;
      end
   end

   // Command, address and data bytes; kept across operations
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         cmd_q <= 8'h00;
         addr_q <= 24'h00_0000;
         dlo_q <= 8'h00;
         dhi_q <= 8'h00;
      end
      else if (hv_rise)
      begin
         cmd_q <= 8'h00; // see RULE26
         addr_q <= 24'h00_0000;
         dlo_q <= 8'h00;
         dhi_q <= 8'h00;
      end
      else if (strobe_rise)
      begin
         case (xa) // see RULE1
            `PPP_XA_CMD: cmd_q <= pin_q.data;
            `PPP_XA_ADDR:
            begin
               case (bs) // see RULE2
                  `PPP_BS_LOW: addr_q[7:0] <= pin_q.data; // see RULE3
                  `PPP_BS_HIGH: addr_q[15:8] <= pin_q.data; // see RULE3
                  `PPP_BS_EXT: addr_q[23:16] <= pin_q.data; // see RULE3
                  default: ;
               endcase
            end
            `PPP_XA_DATA:
            begin
               if (!pin_q.byte_sel_hi) // see RULE4
               begin
                  if (pin_q.byte_sel_lo)
                     dhi_q <= pin_q.data;
                  else
                     dlo_q <= pin_q.data;
               end
            end
            default: ;
         endcase
      end
   end

   // Page buffer word chosen by the low address bits
   always_ff @(posedge ref_clk_i)
   begin
      if (latch_rise && pin_q.byte_sel_lo)
         pbuf_q[addr_q[`PPP_WORD_BITS-1:0]] <= {dhi_q, dlo_q}; // see RULE18 RULE19
      pbuf_rd_data_o <= pbuf_q[pbuf_rd_idx_i];
   end

   // Operation sequencer; busy for the whole operation
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         state_q <= PPP_IDLE;
         cnt_q <= 12'h000;
      end
      else
      begin
         case (state_q)
            PPP_IDLE:
            begin
               if (wr_fall)
               begin
                  case (cmd_q) // see RULE5
                     `PPP_CMD_ERASE:
                     begin
                        state_q <= PPP_ERASE; // see RULE17
                        cnt_q <= 12'(`PPP_ERASE_CYC - 1);
                     end
                     `PPP_CMD_WR_FLASH, `PPP_CMD_WR_EE:
                     begin
                        if (bs == `PPP_BS_LOW)
                        begin
                           state_q <= PPP_PROG; // see RULE20
                           cnt_q <= 12'(`PPP_PROG_CYC - 1);
                        end
                     end
                     `PPP_CMD_WR_FUSE, `PPP_CMD_WR_LOCK:
                     begin
                        state_q <= PPP_PROG;
                        cnt_q <= 12'(`PPP_FUSE_CYC - 1);
                     end
                     default: ;
                  endcase
               end
            end
            PPP_ERASE:
            begin
               if (cnt_q == 12'h000)
                  state_q <= PPP_LOCK_REL; // see RULE14
               else
                  cnt_q <= cnt_q - 12'h001;
            end
            PPP_LOCK_REL: state_q <= PPP_IDLE;
            PPP_PROG:
            begin
               if (cnt_q == 12'h000)
                  state_q <= PPP_IDLE;
               else
                  cnt_q <= cnt_q - 12'h001;
            end
            default: state_q <= PPP_IDLE;
         endcase
      end
   end

   // Fuses survive erase; locks return to unprogrammed after it
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
         fuse_q <= {4{`PPP_BYTE_FF}};
      else if (state_q == PPP_LOCK_REL)
         fuse_q.lock <= `PPP_BYTE_FF; // see RULE14
      else if (wr_fall && cmd_q == `PPP_CMD_WR_LOCK)
         fuse_q.lock <= fuse_q.lock & dlo_q;
      else if (wr_fall && cmd_q == `PPP_CMD_WR_FUSE)
      begin
         case (bs) // see RULE24
            `PPP_BS_LOW: fuse_q.low <= dlo_q;
            `PPP_BS_HIGH: fuse_q.high <= dlo_q;
            `PPP_BS_EXT: fuse_q.ext <= dlo_q;
            default: ;
         endcase
      end
   end

   // Memory-side strobes, one cycle each
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         flash_page_wr_o <= 1'b0;
         ee_page_wr_o <= 1'b0;
         chip_erase_o <= 1'b0;
         ee_erase_o <= 1'b0;
         lock_release_o <= 1'b0;
      end
      else
      begin
         flash_page_wr_o <= wr_fall && cmd_q == `PPP_CMD_WR_FLASH && bs == `PPP_BS_LOW;
         ee_page_wr_o <= wr_fall && cmd_q == `PPP_CMD_WR_EE && bs == `PPP_BS_LOW;
         chip_erase_o <= wr_fall && cmd_q == `PPP_CMD_ERASE; // see RULE14
         ee_erase_o <= wr_fall && cmd_q == `PPP_CMD_ERASE && !eeprom_preserve_fuse_i; // see RULE15
         lock_release_o <= (state_q == PPP_LOCK_REL); // see RULE14
      end
   end

   // Read data selection
   always_comb
   begin
      rd_d = `PPP_BYTE_FF;
      case (cmd_q) // see RULE6
         `PPP_CMD_RD_FLASH: rd_d = pin_q.byte_sel_lo ? flash_rd_data_i[15:8]
                                                    : flash_rd_data_i[7:0];
         `PPP_CMD_RD_EE: rd_d = ee_rd_data_i;
         `PPP_CMD_RD_FUSE:
         begin
            case (bs) // see RULE23
               `PPP_BS_LOW: rd_d = fuse_q.low;
               `PPP_BS_HIGH: rd_d = fuse_q.lock;
               `PPP_BS_EXT: rd_d = fuse_q.ext;
               default: rd_d = fuse_q.high;
            endcase
         end
         `PPP_CMD_RD_SIG:
         begin
            if (pin_q.byte_sel_lo)
               rd_d = (addr_q[7:0] == `PPP_SIG_IDX_CAL) ? CAL_BYTE : `PPP_BYTE_FF;
            else
            begin
               case (addr_q[1:0])
                  2'b00: rd_d = SIG_BYTE0;
                  2'b01: rd_d = SIG_BYTE1;
                  2'b10: rd_d = SIG_BYTE2;
                  default: rd_d = `PPP_BYTE_FF;
               endcase
            end
         end
         default: ;
      endcase
   end

   // Bus drive registered to avoid glitches on the shared data lines
   always_ff @(posedge ref_clk_i or negedge rst_q)
   begin
      if (!rst_q)
      begin
         data_o <= 8'h00;
         data_oe_o <= 1'b0;
      end
      else
      begin
         data_o <= rd_d;
         data_oe_o <= prog_q & ~pin_q.oe_n; // see RULE22
      end
   end

   assign ready_not_busy_o = idle; // see RULE21
   assign prog_mode_o = prog_q;
   assign mem_addr_o = addr_q; // see RULE11
   assign fuses_o = fuse_q;

   property p_erase_busy;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (wr_fall && cmd_q == `PPP_CMD_ERASE) |=> !ready_not_busy_o [*8];
   endproperty
   a_erase_busy: assert property (p_erase_busy) else $error("Erase not busy"); // see RULE17

   property p_prog_busy;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (wr_fall && cmd_q == `PPP_CMD_WR_FLASH && bs == `PPP_BS_LOW)
      |=> !ready_not_busy_o ##0 flash_page_wr_o;
   endproperty
   a_prog_busy: assert property (p_prog_busy) else $error("Page write missing"); // see RULE20

   property p_oe_drive;
      @(posedge ref_clk_i) disable iff (!rst_q)
      data_oe_o |-> $past(!pin_q.oe_n) && $past(prog_q);
   endproperty
   a_oe_drive: assert property (p_oe_drive) else $error("Bus driven without enable"); // see RULE22

   property p_cmd_load;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (strobe_rise && xa == `PPP_XA_CMD) |=> cmd_q == $past(pin_q.data);
   endproperty
   a_cmd_load: assert property (p_cmd_load) else $error("Command not loaded"); // see RULE1

   property p_addr_hi;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (strobe_rise && xa == `PPP_XA_ADDR && bs == `PPP_BS_HIGH)
      |=> addr_q[15:8] == $past(pin_q.data) && $stable(addr_q[7:0]);
   endproperty
   a_addr_hi: assert property (p_addr_hi) else $error("Address high wrong"); // see RULE3

   property p_busy_ignore;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (!idle && !hv_rise) |=> $stable(cmd_q) && $stable(addr_q);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("Strobe taken while busy"); // see RULE26

   property p_entry_fail;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (hv_rise && entry_pins) ##1 pin_q.hv [*6] |-> !prog_q;
   endproperty
   a_entry_fail: assert property (p_entry_fail) else $error("Entered despite pin change"); // see RULE9

   property p_lock_after;
      @(posedge ref_clk_i) disable iff (!rst_q)
      lock_release_o |-> $past(state_q, 2) == PPP_ERASE && fuse_q.lock == `PPP_BYTE_FF;
   endproperty
   a_lock_after: assert property (p_lock_after) else $error("Lock release early"); // see RULE14

   property p_ee_keep;
      @(posedge ref_clk_i) disable iff (!rst_q)
      ee_erase_o |-> !$past(eeprom_preserve_fuse_i) && chip_erase_o;
   endproperty
   a_ee_keep: assert property (p_ee_keep) else $error("EEPROM erased while preserved"); // see RULE15

   property p_fuse_rd;
      @(posedge ref_clk_i) disable iff (!rst_q)
      (cmd_q == `PPP_CMD_RD_FUSE && bs == `PPP_BS_HIGH) |=> data_o == $past(fuse_q.lock);
   endproperty
   a_fuse_rd: assert property (p_fuse_rd) else $error("Lock read wrong"); // see RULE23

endmodule // ppp_top

// ### verification/ppp_prog_model.sv
// Behavioural parallel programmer driving the port pins
`timescale 1ns/1ps
module ppp_prog_model
(
   input wire logic clk_i,
   input wire logic ready_not_busy_i,
   output ppp_pkg::ppp_pins_t pins_o
);
   import ppp_pkg::*;
   initial
   begin
      pins_o = '0;
      pins_o.wr_n = 1'b1;
      pins_o.oe_n = 1'b1;
   end
   // Pins pass two sync flops, so every level is held several cycles
   task automatic hold(input int n = 4);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic sel(input logic [1:0] xa, input logic [1:0] bs);
      {pins_o.action_sel_hi, pins_o.action_sel_lo} = xa;
      {pins_o.byte_sel_hi, pins_o.byte_sel_lo} = bs;
   endtask
   task automatic pulse_strobe();
      pins_o.action_strobe = 1'b1;
      hold();
      pins_o.action_strobe = 1'b0;
      hold();
   endtask
   task automatic enter(input logic bad);
      pins_o.hv = 1'b0;
      hold();
      repeat (6) pulse_strobe();
      sel(2'b00, 2'b00);
      pins_o.page_latch_strobe = bad;
      hold(6);
      pins_o.hv = 1'b1;
      hold(8);
      pins_o.page_latch_strobe = 1'b0;
      hold(2500);
   endtask
   task automatic load(input logic [1:0] xa, input logic [1:0] bs, input logic [7:0] d);
      sel(xa, bs);
      pins_o.data = d;
      hold();
      pulse_strobe();
   endtask
   task automatic latch();
      pins_o.byte_sel_lo = 1'b1;
      hold();
      pins_o.page_latch_strobe = 1'b1;
      hold();
      pins_o.page_latch_strobe = 1'b0;
      hold();
   endtask
   task automatic write(input logic [1:0] bs);
      sel(2'b11, bs);
      hold();
      pins_o.wr_n = 1'b0;
      hold(6);
      pins_o.wr_n = 1'b1;
   endtask
   // Bounded so a stuck busy line cannot hang the run
   task automatic wait_ready(output logic ok);
      ok = 1'b0;
      repeat (2200)
      begin
         @(negedge clk_i);
         if (ready_not_busy_i === 1'b1)
         begin
            ok = 1'b1;
            break;
         end
      end
      hold();
   endtask
   task automatic read(input logic [1:0] bs);
      sel(2'b11, bs);
      pins_o.oe_n = 1'b0;
      // Bus released to the device, so our copy no longer holds the last byte
      pins_o.data = ~pins_o.data;
      hold(6);
   endtask
   task automatic read_end();
      pins_o.oe_n = 1'b1;
      hold(6);
   endtask
endmodule // ppp_prog_model

// ### verification/test_ppp_top.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/1ps
module test_ppp_top;
   import ppp_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   ppp_pins_t pins;
   logic ee_keep = 1'b0;
   logic [15:0] flash_rd = 16'hC35A;
   logic [7:0] ee_rd = 8'h96;
   logic [5:0] rd_idx = 6'h00;
   logic [15:0] pbuf_rd;
   logic [23:0] mem_addr;
   logic [7:0] rd_byte;
   logic data_oe, rdy, prog, fw, ew, ce, ee, lr, ok;
   ppp_fuses_t fuses;
   int n_mismatch = 0;
   int compares = 0;
   logic [7:0] n_ce = 8'h00, n_ee = 8'h00, n_fw = 8'h00, n_ew = 8'h00, n_lr = 8'h00;
   always #10 ref_clk_i = ~ref_clk_i;
   ppp_top i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
      .eeprom_preserve_fuse_i(ee_keep), .flash_rd_data_i(flash_rd), .ee_rd_data_i(ee_rd),
      .pbuf_rd_idx_i(rd_idx), .pbuf_rd_data_o(pbuf_rd), .mem_addr_o(mem_addr),
      .data_o(rd_byte), .data_oe_o(data_oe), .ready_not_busy_o(rdy), .prog_mode_o(prog),
      .flash_page_wr_o(fw), .ee_page_wr_o(ew), .chip_erase_o(ce), .ee_erase_o(ee),
      .lock_release_o(lr), .fuses_o(fuses));
   ppp_prog_model i_prog (.clk_i(ref_clk_i), .ready_not_busy_i(rdy), .pins_o(pins));
   // Pulse outputs last one cycle, so they are counted at every edge
   always @(posedge ref_clk_i)
   begin
      n_ce <= n_ce + 8'(ce === 1'b1);
      n_ee <= n_ee + 8'(ee === 1'b1);
      n_fw <= n_fw + 8'(fw === 1'b1);
      n_ew <= n_ew + 8'(ew === 1'b1);
      n_lr <= n_lr + 8'(lr === 1'b1);
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ld(input logic [1:0] xa, input logic [1:0] bs, input logic [7:0] d);
      i_prog.load(xa, bs, d);
   endtask
   task automatic wr_wait(input logic [1:0] bs);
      i_prog.write(bs);
      i_prog.wait_ready(ok);
      check(32'(ok), 32'h1);
   endtask
   task automatic rd(input logic [1:0] bs, input logic [7:0] exp);
      i_prog.read(bs);
      check(32'(rd_byte), 32'(exp));
      check(32'(data_oe), 32'h1);
      i_prog.read_end();
      check(32'(data_oe), 32'h0);
   endtask
   task automatic t_entry();
      i_prog.enter(1'b1);
      check(32'(prog), 32'h0);
      i_prog.enter(1'b0);
      check(32'(prog), 32'h1);
      check(32'(rdy), 32'h1);
      check(32'(mem_addr), 32'h0);
      $display("entry test done");
   endtask
   task automatic t_addr();
      ld(2'b00, 2'b00, 8'h45);
      ld(2'b00, 2'b01, 8'h12);
      ld(2'b00, 2'b10, 8'h03);
      check(32'(mem_addr), 32'h0003_1245);
      ld(2'b00, 2'b11, 8'hFF);
      ld(2'b11, 2'b00, 8'hEE);
      check(32'(mem_addr), 32'h0003_1245);
      $display("address test done");
   endtask
   task automatic t_latch();
      ld(2'b01, 2'b00, 8'hA5);
      ld(2'b01, 2'b01, 8'h3C);
      ld(2'b01, 2'b10, 8'h77);
      i_prog.latch();
      rd_idx = 6'h05;
      i_prog.hold(2);
      check(32'(pbuf_rd), 32'h3CA5);
      $display("page latch test done");
   endtask
   task automatic t_fuse();
      logic [7:0] fv [3] = '{8'h5A, 8'h6B, 8'h7C};
      ld(2'b10, 2'b00, 8'h40);
      for (int i = 0; i < 3; i++)
      begin
         ld(2'b01, 2'b00, fv[i]);
         wr_wait(2'(i));
      end
      check(32'({fuses.low, fuses.high, fuses.ext}), 32'h005A_6B7C);
      ld(2'b10, 2'b00, 8'h20);
      ld(2'b01, 2'b00, 8'h00);
      wr_wait(2'b00);
      check(32'(fuses.lock), 32'h0);
      $display("fuse test done");
   endtask
   task automatic t_erase();
      ld(2'b10, 2'b00, 8'h80);
      i_prog.write(2'b00);
      check(32'(rdy), 32'h0);
      i_prog.wait_ready(ok);
      check(32'({ok, n_ce, n_ee, n_lr}), 32'h0101_0101);
      check(32'(fuses), 32'h5A6B_7CFF);
      check(32'(mem_addr), 32'h0003_1245);
      ee_keep = 1'b1;
      wr_wait(2'b00);
      check(32'({n_ce, n_ee}), 32'h0201);
      ee_keep = 1'b0;
      $display("erase test done");
   endtask
   task automatic t_write();
      // Unlatched words stay erased, so only one word goes to the buffer
      ld(2'b10, 2'b00, 8'h10);
      i_prog.write(2'b01);
      check(32'(rdy), 32'h1);
      i_prog.write(2'b00);
      check(32'(rdy), 32'h0);
      i_prog.wait_ready(ok);
      check(32'({ok, n_fw}), 32'h0101);
      ld(2'b10, 2'b00, 8'h11);
      wr_wait(2'b00);
      check(32'({n_fw, n_ew}), 32'h0101);
      $display("page write test done");
   endtask
   task automatic t_read();
      ld(2'b10, 2'b00, 8'h04);
      rd(2'b00, 8'h5A);
      rd(2'b01, 8'hFF);
      rd(2'b10, 8'h7C);
      rd(2'b11, 8'h6B);
      ld(2'b10, 2'b00, 8'h02);
      rd(2'b00, 8'h5A);
      rd(2'b01, 8'hC3);
      flash_rd = 16'h7DB2;
      rd(2'b01, 8'h7D);
      ld(2'b10, 2'b00, 8'h03);
      rd(2'b00, 8'h96);
      ee_rd = 8'h69;
      rd(2'b00, 8'h69);
      $display("read test done");
   endtask
   task automatic t_sig();
      ld(2'b10, 2'b00, 8'h08);
      // Only the low address byte is reloaded; high byte kept
      ld(2'b00, 2'b00, 8'h00);
      rd(2'b00, i_dut.SIG_BYTE0);
      rd(2'b01, i_dut.CAL_BYTE);
      ld(2'b00, 2'b00, 8'h01);
      rd(2'b00, i_dut.SIG_BYTE1);
      ld(2'b00, 2'b00, 8'h03);
      rd(2'b00, 8'hFF);
      $display("signature test done");
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge ref_clk_i);
      n_mismatch++;
      summarize();
   end
   initial
   begin
      repeat (8) @(negedge ref_clk_i);
      check(32'({rdy, prog}), 32'h2);
      rst_n_i = 1'b1;
      i_prog.hold(4);
      t_entry();
      t_addr();
      t_latch();
      t_fuse();
      t_erase();
      t_write();
      t_read();
      t_sig();
      summarize();
   end
endmodule // test_ppp_top
